// ### shared/std_timer_pkg.sv
// constants, field layouts and types shared by the standard timer block
package std_timer_pkg;

    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL0    = 8'h00;
    localparam logic [7:0] OFF_CTRL1    = 8'h04;
    localparam logic [7:0] OFF_CNT_LO   = 8'h08;
    localparam logic [7:0] OFF_CNT_HI   = 8'h0c;
    localparam logic [7:0] OFF_CMPA_LO  = 8'h10;
    localparam logic [7:0] OFF_CMPA_HI  = 8'h14;
    localparam logic [7:0] OFF_CMPP     = 8'h18;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h1c;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h20;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0]  RST_BYTE  = 8'h00;
    localparam logic [15:0] RST_COUNT = 16'h0000;
    localparam logic [1:0]  RST_IRQ   = 2'h0;

    // interrupt status bit positions
    localparam int IRQ_A_BIT = 0;
    localparam int IRQ_P_BIT = 1;

    // ------------------------------------------------------------------
    // pin action codes
    // ------------------------------------------------------------------
    localparam logic [1:0] ACT_CMP_NONE   = 2'h0;
    localparam logic [1:0] ACT_CMP_LOW    = 2'h1;
    localparam logic [1:0] ACT_CMP_HIGH   = 2'h2;
    localparam logic [1:0] ACT_CMP_TOGGLE = 2'h3;
    localparam logic [1:0] ACT_PWM_INACT  = 2'h0;
    localparam logic [1:0] ACT_PWM_ACT    = 2'h1;
    localparam logic [1:0] ACT_PWM_RUN    = 2'h2;
    localparam logic [1:0] ACT_PWM_SINGLE = 2'h3;
    localparam logic [1:0] ACT_CAP_RISE   = 2'h0;
    localparam logic [1:0] ACT_CAP_FALL   = 2'h1;
    localparam logic [1:0] ACT_CAP_BOTH   = 2'h2;

    // ------------------------------------------------------------------
    // counter clock select codes
    // ------------------------------------------------------------------
    localparam logic [2:0] CKS_DIV4   = 3'h0;
    localparam logic [2:0] CKS_DIV1   = 3'h1;
    localparam logic [2:0] CKS_DIV16  = 3'h2;
    localparam logic [2:0] CKS_DIV64  = 3'h3;
    localparam logic [2:0] CKS_SUB0   = 3'h4;
    localparam logic [2:0] CKS_SUB1   = 3'h5;
    localparam logic [2:0] CKS_PIN_RE = 3'h6;

    typedef enum logic [1:0] {
        MODE_COMPARE = 2'h0,
        MODE_CAPTURE = 2'h1,
        MODE_PWM     = 2'h2,
        MODE_TIMER   = 2'h3
    } mode_t;

    typedef struct packed {
        logic       pause;
        logic [2:0] clk_sel;
        logic       counter_on;
        logic [2:0] unused;
    } ctrl0_t;

    typedef struct packed {
        mode_t      operating_mode_sel;
        logic [1:0] pin_action_sel;
        logic       output_initial_level;
        logic       output_invert;
        logic       duty_period_swap;
        logic       clear_source_sel;
    } ctrl1_t;

    // wishbone classic request bundle
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } wb_req_t;

endpackage

// ### src/std_timer_output_clear_control.sv
// standard timer: pin action, output control, clear source and count readout
//
// The Wishbone register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
// Behaviour
// - compare mode, on A match pin: 00 hold, 01 low, 10 high, 11 toggle.
// - pwm mode, action: 00 inactive, 01 active, 10 pwm, 11 single pulse.
// - capture mode trigger: 00 rising, 01 falling, 10 both, 11 disabled.
// - A match requesting the level already present leaves pin unchanged.
// - rising counter_on returns the compare output to its initial level.
// - compare mode initial level: 0 low, 1 high.
// - pwm mode initial level bit sets active level: 0 low, 1 high.
// - single pulse level set by initial level bit on counter_on rise.
// - invert bit inverts the pin; both bits ignored in timer mode.
// - swap 0: P period, A duty; swap 1: P duty, A period.
// - clear source 1 clears the counter on comparator A match.
// - clear source 0 clears on P match, or overflow when P is zero.
// - clear source ignored in pwm, single pulse and capture modes.
// - counter readable as two zero-reset read-only bytes, low and high.
// - high byte read copies low byte to buffer; low read returns buffer.
// - counter_on rise clears counter; software cannot otherwise change it.
// - mode: 00 compare, 01 capture, 10 pwm/single pulse, 11 timer.
module std_timer_output_clear_control
    import std_timer_pkg::*;
(
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire logic               cyc_i,
    input  wire logic               stb_i,
    input  wire logic               we_i,
    input  wire logic [7:0]         adr_i,
    input  wire logic [3:0]         sel_i,
    input  wire logic [31:0]        dat_i,
    output logic      [31:0]        dat_o,
    output logic                    ack_o,
    output logic                    irq_o,
    input  wire logic               sub_tick_i,
    input  wire logic               counter_clk_pin_i,
    input  wire logic               capture_input_pin_i,
    output logic                    timer_output_pin_o,
    output logic                    timer_output_pin_oe_o
);
    import std_timer_pkg::*;

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    wb_req_t req;
    assign req = '{cyc: cyc_i, stb: stb_i, we: we_i, adr: adr_i,
                   sel: sel_i, dat: dat_i};

    logic        ack_r;
    logic [31:0] dat_r;
    wire         access  = req.cyc & req.stb & ~ack_r;
    wire         wr      = access & req.we & req.sel[0];
    wire         rd      = access & ~req.we;
    wire [7:0]   wbyte   = req.dat[7:0];

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        return a == o;
    endfunction

    wire wr_ctrl0  = wr & hit(req.adr, OFF_CTRL0);
    wire wr_ctrl1  = wr & hit(req.adr, OFF_CTRL1);
    wire wr_a_lo   = wr & hit(req.adr, OFF_CMPA_LO);
    wire wr_a_hi   = wr & hit(req.adr, OFF_CMPA_HI);
    wire wr_p      = wr & hit(req.adr, OFF_CMPP);
    wire wr_stat   = wr & hit(req.adr, OFF_IRQ_STAT);
    wire wr_mask   = wr & hit(req.adr, OFF_IRQ_MASK);
    wire rd_cnt_hi = rd & hit(req.adr, OFF_CNT_HI);

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    ctrl0_t      ctrl0_r;
    ctrl1_t      ctrl1_r;
    logic [15:0] cnt_r;
    logic [15:0] cmp_a_r;
    logic [7:0]  cmp_p_r;
    logic [7:0]  rd_buf_r;
    logic [7:0]  wr_buf_r;
    logic [1:0]  stat_r;
    logic [1:0]  mask_r;
    logic        on_d_r;
    logic        level_r;
    logic [5:0]  pre_r;
    logic [2:0]  ck_sync_r;
    logic [2:0]  cap_sync_r;

    mode_t mode;
    assign mode = ctrl1_r.operating_mode_sel;
    wire [1:0] act = ctrl1_r.pin_action_sel;
    wire       ic  = ctrl1_r.output_initial_level;

    wire is_cmp  = (mode == MODE_COMPARE);
    wire is_cap  = (mode == MODE_CAPTURE);
    wire is_pwm  = (mode == MODE_PWM);
    wire is_tmr  = (mode == MODE_TIMER);
    wire single  = is_pwm & (act == ACT_PWM_SINGLE);

    // ------------------------------------------------------------------
    // counter clock
    // ------------------------------------------------------------------
    wire ck_rise = ck_sync_r[1] & ~ck_sync_r[2];
    wire ck_fall = ~ck_sync_r[1] & ck_sync_r[2];
    wire [2:0] cks = ctrl0_r.clk_sel;
    wire tick_src =
        (cks == CKS_DIV4)   ? (pre_r[1:0] == 2'h3) :
        (cks == CKS_DIV1)   ? 1'b1 :
        (cks == CKS_DIV16)  ? (pre_r[3:0] == 4'hf) :
        (cks == CKS_DIV64)  ? (pre_r == 6'h3f) :
        (cks == CKS_SUB0 || cks == CKS_SUB1) ? sub_tick_i :
        (cks == CKS_PIN_RE) ? ck_rise : ck_fall;

    wire on_rise = ctrl0_r.counter_on & ~on_d_r;
    wire run     = ctrl0_r.counter_on & ~ctrl0_r.pause & ~on_rise;
    wire tick    = run & tick_src;

    // ------------------------------------------------------------------
    // comparators
    // ------------------------------------------------------------------
    wire [15:0] cnt_inc = cnt_r + 16'h0001;
    wire [15:0] p_full  = {cmp_p_r, 8'h00};
    wire a_match = tick & (cmp_a_r != 16'h0000) & (cnt_inc == cmp_a_r);
    wire p_match = tick & (cmp_p_r != 8'h00) & (cnt_inc == p_full);
    wire ovf     = tick & (cnt_r == 16'hffff);

    // pwm period and duty by swap bit
    wire        dpx      = ctrl1_r.duty_period_swap;
    wire        per_hit  = dpx ? a_match : p_match;
    wire [16:0] duty_v   = dpx ? ((cmp_p_r == 8'h00) ? 17'h10000
                                  : {1'b0, p_full})
                               : {1'b0, cmp_a_r};
    wire        pwm_act  = ({1'b0, cnt_r} < duty_v);

    // counter clear source
    wire clr_src = (is_cmp | is_tmr)
                 ? (ctrl1_r.clear_source_sel ? a_match : p_match)
                 : (is_pwm ? per_hit : p_match);
    // a wrap at ffff also restarts from zero, whatever P and the clear source hold
    wire cnt_clr = clr_src | ovf;

    // single pulse ends on comparator A match
    wire sp_end = single & a_match;

    // ------------------------------------------------------------------
    // capture edges
    // ------------------------------------------------------------------
    wire cap_r = cap_sync_r[1] & ~cap_sync_r[2];
    wire cap_f = ~cap_sync_r[1] & cap_sync_r[2];
    wire cap_ev = is_cap & ctrl0_r.counter_on &
        ((act == ACT_CAP_RISE) ? cap_r :
         (act == ACT_CAP_FALL) ? cap_f :
         (act == ACT_CAP_BOTH) ? (cap_r | cap_f) : 1'b0);

    // ------------------------------------------------------------------
    // interrupt events
    // ------------------------------------------------------------------
    wire ev_a = is_cap ? cap_ev : a_match;
    wire ev_p = p_match & ~((is_cmp | is_tmr) & ctrl1_r.clear_source_sel);
    wire [1:0] ev = {ev_p, ev_a};
    wire [1:0] stat_nxt = (stat_r & ~(wr_stat ? wbyte[1:0] : 2'h0)) | ev;

    // ------------------------------------------------------------------
    // output level
    // ------------------------------------------------------------------
    logic level_nxt;
    always_comb
    begin
        level_nxt = level_r;
        if (on_rise)
        begin
            level_nxt = ic;
        end
        else if (is_cmp & a_match)
        begin
            case (act)
                ACT_CMP_LOW:    level_nxt = 1'b0;
                ACT_CMP_HIGH:   level_nxt = 1'b1;
                ACT_CMP_TOGGLE: level_nxt = ~level_r;
                default:        level_nxt = level_r;
            endcase
        end
        else if (single & sp_end)
        begin
            level_nxt = ~ic;
        end
    end

    logic pin_nxt;
    always_comb
    begin
        pin_nxt = 1'b0;
        if (is_pwm)
        begin
            case (act)
                ACT_PWM_INACT: pin_nxt = ~ic;
                ACT_PWM_ACT:   pin_nxt = ic;
                ACT_PWM_RUN:   pin_nxt = pwm_act ? ic : ~ic;
                default:       pin_nxt = level_nxt;
            endcase
        end
        else if (is_cmp)
        begin
            pin_nxt = level_nxt;
        end
        if (!is_tmr)
        begin
            pin_nxt = pin_nxt ^ ctrl1_r.output_invert;
        end
    end

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------
    wire [7:0] rd_byte =
        hit(req.adr, OFF_CTRL0)    ? ctrl0_r :
        hit(req.adr, OFF_CTRL1)    ? ctrl1_r :
        hit(req.adr, OFF_CNT_LO)   ? rd_buf_r :
        hit(req.adr, OFF_CNT_HI)   ? cnt_r[15:8] :
        hit(req.adr, OFF_CMPA_LO)  ? cmp_a_r[7:0] :
        hit(req.adr, OFF_CMPA_HI)  ? cmp_a_r[15:8] :
        hit(req.adr, OFF_CMPP)     ? cmp_p_r :
        hit(req.adr, OFF_IRQ_STAT) ? {6'h00, stat_r} :
        hit(req.adr, OFF_IRQ_MASK) ? {6'h00, mask_r} : 8'h00;

    wire [15:0] cnt_nxt = on_rise ? RST_COUNT :
                          cnt_clr ? RST_COUNT :
                          tick    ? cnt_inc : cnt_r;

    ctrl0_t ctrl0_nxt;
    always_comb
    begin
        ctrl0_nxt = ctrl0_r;
        if (wr_ctrl0)
        begin
            ctrl0_nxt = {wbyte[7:3], 3'h0};
        end
        else if (sp_end)
        begin
            ctrl0_nxt.counter_on = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl0_r    <= RST_BYTE;
            ctrl1_r    <= RST_BYTE;
            cnt_r      <= RST_COUNT;
            cmp_a_r    <= RST_COUNT;
            cmp_p_r    <= RST_BYTE;
            rd_buf_r   <= RST_BYTE;
            wr_buf_r   <= RST_BYTE;
            stat_r     <= RST_IRQ;
            mask_r     <= RST_IRQ;
            on_d_r     <= 1'b0;
            level_r    <= 1'b0;
            pre_r      <= 6'h00;
            ck_sync_r  <= 3'h0;
            cap_sync_r <= 3'h0;
            ack_r      <= 1'b0;
            dat_r      <= 32'h0000_0000;
            irq_o      <= 1'b0;
            timer_output_pin_o    <= 1'b0;
            timer_output_pin_oe_o <= 1'b0;
        end
        else
        begin
            ctrl0_r    <= ctrl0_nxt;
            ctrl1_r    <= wr_ctrl1 ? ctrl1_t'(wbyte) : ctrl1_r;
            cnt_r      <= cnt_nxt;
            if (cap_ev)
                cmp_a_r <= cnt_r;
            else if (wr_a_hi)
                cmp_a_r <= {wbyte, wr_buf_r};
            cmp_p_r    <= wr_p ? wbyte : cmp_p_r;
            rd_buf_r   <= rd_cnt_hi ? cnt_r[7:0] : rd_buf_r;
            wr_buf_r   <= wr_a_lo ? wbyte : wr_buf_r;
            stat_r     <= stat_nxt;
            mask_r     <= wr_mask ? wbyte[1:0] : mask_r;
            on_d_r     <= ctrl0_r.counter_on;
            level_r    <= level_nxt;
            pre_r      <= pre_r + 6'h01;
            ck_sync_r  <= {ck_sync_r[1:0], counter_clk_pin_i};
            cap_sync_r <= {cap_sync_r[1:0], capture_input_pin_i};
            ack_r      <= access;
            dat_r      <= rd ? {24'h000000, rd_byte} : 32'h0000_0000;
            irq_o      <= |(stat_nxt & mask_r);
            timer_output_pin_o    <= pin_nxt;
            timer_output_pin_oe_o <= ~is_tmr;
        end
    end

    assign ack_o = ack_r;
    assign dat_o = dat_r;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_CMP_HIGH: assert property (is_cmp & a_match & ~on_rise &
        act == ACT_CMP_HIGH |=> level_r)
        else $error("compare high action missed");
    AST_CMP_TOGGLE: assert property (is_cmp & a_match & ~on_rise &
        act == ACT_CMP_TOGGLE |=> level_r != $past(level_r))
        else $error("toggle action missed");
    AST_PWM_FORCE: assert property (is_pwm & act == ACT_PWM_ACT &
        ~wr_ctrl1 |=> timer_output_pin_o == (ic ^ ctrl1_r.output_invert))
        else $error("forced active level wrong");
    AST_CAP_OFF: assert property (is_cap & act == 2'h3 |-> ~cap_ev)
        else $error("capture while disabled");
    AST_CMP_NONE: assert property (is_cmp & act == ACT_CMP_NONE &
        ~on_rise |=> level_r == $past(level_r))
        else $error("pin moved with no action");
    AST_ON_LEVEL: assert property (on_rise |=> level_r == $past(ic))
        else $error("initial level not restored");
    AST_ON_CLEAR: assert property (on_rise |=> cnt_r == 16'h0000)
        else $error("counter not cleared on start");
    AST_CLR_A: assert property ((is_cmp | is_tmr) &
        ctrl1_r.clear_source_sel & a_match & ~on_rise
        |=> cnt_r == 16'h0000)
        else $error("A match did not clear");
    AST_CLR_P: assert property ((is_cmp | is_tmr) &
        ~ctrl1_r.clear_source_sel & a_match & ~p_match & ~on_rise &
        cnt_inc != 16'h0000 |=> cnt_r != 16'h0000)
        else $error("A match cleared with P source");
    AST_RD_BUF: assert property (rd_cnt_hi ##1 ack_r ##2
        (rd & hit(req.adr, OFF_CNT_LO)) |=>
        dat_r[7:0] == $past(cnt_r[7:0], 4))
        else $error("low byte buffer wrong");
    AST_TMR_OE: assert property (is_tmr |=> ~timer_output_pin_oe_o)
        else $error("pin driven in timer mode");
    AST_ACK: assert property (access |=> ack_r ##1 ~ack_r)
        else $error("ack not a single pulse");

    COV_TOGGLE: cover property (is_cmp & a_match & act == ACT_CMP_TOGGLE);
    COV_PWM:    cover property (is_pwm & per_hit & act == ACT_PWM_RUN);
    COV_CAP:    cover property (cap_ev ##1 irq_o);
    COV_SP:     cover property (sp_end);

endmodule // std_timer_output_clear_control

// ### dv/std_timer_output_clear_control_tb_top.sv
// self-checking bench for the standard timer output and clear control
`timescale 1ns/100ps
`define CHK(nm, ex, got) \
    begin \
        checks++; \
        if ((got) !== (ex)) \
        begin \
            n_mismatch++; \
            $display("[ERR] %s exp %0h got %0h", nm, ex, got); \
        end \
    end
module std_timer_output_clear_control_tb_top;
    import std_timer_pkg::*;
    logic        clk  = 1'b0;
    logic        rst  = 1'b1;
    logic        cyc  = 1'b0;
    logic        stb  = 1'b0;
    logic        we   = 1'b0;
    logic [7:0]  adr  = 8'h00;
    logic [3:0]  sel  = 4'h0;
    logic [31:0] dat  = 32'h00000000;
    logic        cap  = 1'b0;
    logic [31:0] rdat;
    logic        ack;
    logic        irq;
    logic        pin;
    logic        oe;
    logic [31:0] q;
    logic [15:0] v1;
    logic [15:0] v2;
    logic [15:0] mx;
    logic [7:0]  b1;
    logic [4:0]  ce;
    logic [5:0]  pe;
    int          n_mismatch = 0;
    int          checks     = 0;
    int          cycles     = 0;
    int          k;
    // compare entries: initial, action, invert, level after matches
    localparam logic [4:0] CMP_TAB [0:5] =
        '{5'h11, 5'h14, 5'h19, 5'h09, 5'h04, 5'h17};
    // pwm entries: initial, invert, swap, clear source, action
    localparam logic [5:0] PWM_TAB [0:6] =
        '{6'h22, 6'h02, 6'h32, 6'h2a, 6'h26, 6'h20, 6'h21};
    localparam int PWM_EXP [0:6] = '{128, 384, 384, 512, 128, 0, 512};
    localparam logic [7:0] RST_ADR [0:5] =
        '{OFF_CNT_LO, OFF_CNT_HI, OFF_CTRL0, OFF_CTRL1, OFF_IRQ_STAT, 8'h3c};

    always #20 clk = ~clk;

    std_timer_output_clear_control dut_u (
        .clk_i                 (clk),
        .rst_i                 (rst),
        .cyc_i                 (cyc),
        .stb_i                 (stb),
        .we_i                  (we),
        .adr_i                 (adr),
        .sel_i                 (sel),
        .dat_i                 (dat),
        .dat_o                 (rdat),
        .ack_o                 (ack),
        .irq_o                 (irq),
        .sub_tick_i            (1'b0),
        .counter_clk_pin_i     (1'b0),
        .capture_input_pin_i   (cap),
        .timer_output_pin_o    (pin),
        .timer_output_pin_oe_o (oe)
    );

    // --------------------------------------------------------------
    // run control
    // --------------------------------------------------------------
    task automatic final_report;
        $display("mismatches %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_mismatch++;
            final_report();
        end
    end

    // --------------------------------------------------------------
    // bus tasks
    // --------------------------------------------------------------
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [7:0] d, output logic [31:0] r);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        sel <= 4'hf;
        dat <= {24'h000000, d};
        do @(posedge clk); while (ack !== 1'b1);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        wb(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        wb(1'b0, a, 8'h00, r);
    endtask
    task automatic rdcnt(output logic [15:0] c);
        logic [31:0] r;
        rd(OFF_CNT_HI, r);
        c[15:8] = r[7:0];
        rd(OFF_CNT_LO, r);
        c[7:0] = r[7:0];
    endtask
    // stop, reconfigure, restart so counter_on sees a rising edge
    task automatic run(input logic [7:0] c1);
        wr(OFF_CTRL0, 8'h10);
        wr(OFF_CTRL1, c1);
        wr(OFF_CTRL0, 8'h18);
    endtask
    task automatic seta(input logic [15:0] a);
        wr(OFF_CMPA_LO, a[7:0]);
        wr(OFF_CMPA_HI, a[15:8]);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic high_for(input int n, output int h);
        h = 0;
        repeat (n)
        begin
            @(posedge clk);
            if (pin === 1'b1)
                h++;
        end
    endtask

    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial
    begin
        idle(2);
        rst <= 1'b0;
        foreach (RST_ADR[i])
        begin
            rd(RST_ADR[i], q);
            `CHK("reset read", 32'h00000000, q)
        end
        `CHK("oe after reset", 1'b1, oe)
        seta(16'h0040);
        foreach (CMP_TAB[i])
        begin
            ce = CMP_TAB[i];
            run({2'b00, ce[3:2], ce[4], ce[1], 2'b01});
            idle(3);
            `CHK("cmp initial pin", ce[4] ^ ce[1], pin)
            idle(200);
            `CHK("cmp matched pin", ce[0], pin)
        end
        repeat (8)
        begin
            rdcnt(v1);
            `CHK("count below A", 1'b1, v1 < 16'h0040)
        end
        rd(OFF_IRQ_STAT, q);
        `CHK("stat clear on A", 2'b01, q[1:0])
        run(8'h39);
        idle(3);
        `CHK("toggle initial", 1'b1, pin)
        k = 0;
        b1[0] = pin;
        repeat (256)
        begin
            @(posedge clk);
            if (pin !== b1[0])
                k++;
            b1[0] = pin;
        end
        `CHK("toggle count", 4, k)
        wr(OFF_CMPP, 8'h01);
        wr(OFF_IRQ_STAT, 8'h03);
        run(8'h00);
        mx = 16'h0000;
        repeat (16)
        begin
            rdcnt(v1);
            if (v1 > mx)
                mx = v1;
            idle(20);
        end
        `CHK("count below P", 1'b1, mx < 16'h0100)
        `CHK("A did not clear", 1'b1, mx >= 16'h0040)
        wr(OFF_CTRL0, 8'h10);
        rd(OFF_IRQ_STAT, q);
        `CHK("stat both", 2'b11, q[1:0])
        `CHK("irq masked", 1'b0, irq)
        wr(OFF_IRQ_MASK, 8'h01);
        idle(2);
        `CHK("irq unmasked", 1'b1, irq)
        wr(OFF_IRQ_STAT, 8'h01);
        rd(OFF_IRQ_STAT, q);
        `CHK("stat w1c", 2'b10, q[1:0])
        `CHK("irq after clear", 1'b0, irq)
        wr(OFF_IRQ_MASK, 8'h03);
        idle(2);
        `CHK("irq on P", 1'b1, irq)
        wr(OFF_IRQ_STAT, 8'h02);
        idle(2);
        `CHK("irq all clear", 1'b0, irq)
        wr(OFF_CTRL0, 8'h18);
        rd(OFF_CNT_HI, q);
        rd(OFF_CNT_LO, q);
        b1 = q[7:0];
        rd(OFF_CNT_LO, q);
        `CHK("low byte held", b1, q[7:0])
        foreach (PWM_TAB[i])
        begin
            pe = PWM_TAB[i];
            run({2'b10, pe[1:0], pe[5], pe[4], pe[3], pe[2]});
            idle(20);
            high_for(512, k);
            `CHK("pwm high cycles", PWM_EXP[i], k)
        end
        run(8'hb8);
        idle(3);
        `CHK("pulse start", 1'b1, pin)
        idle(200);
        `CHK("pulse end", 1'b0, pin)
        rd(OFF_CTRL0, q);
        `CHK("pulse stop", 32'h00000010, q)
        for (int a = 0; a < 4; a++)
        begin
            run({2'b01, 2'(a), 4'h0});
            seta(16'h0000);
            wr(OFF_IRQ_STAT, 8'h03);
            @(posedge clk);
            cap <= 1'b1;
            idle(8);
            rd(OFF_IRQ_STAT, q);
            `CHK("capture rise", (a == 0 || a == 2), q[0])
            wr(OFF_IRQ_STAT, 8'h03);
            @(posedge clk);
            cap <= 1'b0;
            idle(8);
            rd(OFF_IRQ_STAT, q);
            `CHK("capture fall", (a == 1 || a == 2), q[0])
        end
        wr(OFF_CMPP, 8'h00);
        run(8'hf4);
        idle(1000);
        wr(OFF_CTRL0, 8'h10);
        rdcnt(v1);
        `CHK("free run", 1'b1, v1 >= 16'h0300)
        `CHK("timer oe", 1'b0, oe)
        `CHK("timer pin", 1'b0, pin)
        wr(OFF_CNT_HI, 8'hff);
        rdcnt(v2);
        `CHK("count retained", v1, v2)
        wr(OFF_CTRL0, 8'h18);
        rdcnt(v2);
        `CHK("count cleared", 1'b1, v2 < 16'h0020)
        final_report();
    end
endmodule // std_timer_output_clear_control_tb_top
